// ---- design/fwrt_pkg.sv ----
// Purpose: constants and carriers for the flash write/reset sequencer host
// Assumes: 50 MHz system clock, 20 ns period
// Notes: times in ns, us or s as each name says, cycle counts derived here
package fwrt_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // least times round up
  localparam int unsigned WRITE_PULSE_LOW_NS = 50;
  localparam int unsigned WRITE_PULSE_HIGH_NS = 25;
  localparam int unsigned RESET_LOW_NS = 100;
  localparam int unsigned RESET_RECOVERY_NS = 150;
  localparam int unsigned ACCESS_NS = 75;
  localparam int unsigned BUSY_SETTLE_NS = 100;
  localparam int unsigned RESUME_SUSPEND_GAP_US = 500;
  localparam int unsigned RESET_ABORT_US = 22;
  localparam int unsigned CHIP_ERASE_MAX_S = 1400;
  localparam int unsigned WP_CYC = (WRITE_PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WPH_CYC = (WRITE_PULSE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_CYC = (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYC =
    (ACCESS_NS + BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYC = RESUME_SUSPEND_GAP_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned ABORT_CYC = RESET_ABORT_US * 1000 / CLK_PERIOD_NS;
  localparam longint unsigned TIMEOUT_CYC =
    64'(CHIP_ERASE_MAX_S) * 64'd1000000000 / 64'(CLK_PERIOD_NS);
  localparam int CNT_W = 16;
  localparam int TO_W = 37;
  localparam logic [15:0] CMD_ERASE_RESUME = 16'h00d0;
  localparam logic [15:0] CMD_ERASE_SUSPEND = 16'h00b0;
  typedef struct packed {
    logic [22:0] addr;
    logic [15:0] data;
    logic suspend;
    logic resume;
  } fwrt_req_s;
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic rst_n;
  } fwrt_strobe_s;
  typedef enum logic [2:0] {
    FWRT_RESET = 3'b000,
    FWRT_RECOVER = 3'b001,
    FWRT_IDLE = 3'b010,
    FWRT_PULSE = 3'b011,
    FWRT_HIGH = 3'b100,
    FWRT_SETTLE = 3'b101
  } fwrt_state_e;
endpackage

// ---- design/fwrt_host.sv ----
// Purpose: host sequencer framing flash write cycles and reset
// Assumes: inputs synchronous to sys_clk_i
// Notes: one write per request, busy watched on ready_busy_n
// Contract
// R01: write framed by chip enable or write strobe
// R02: write pulse low at least 50 ns
// R03: strobes high at least 25 ns between
// R04: status bit clears within access plus 50
// R05: busy pin low within 100 ns
// R06: busy reset aborts within 22 us
// R07: idle reset completes within 100 ns
// R08: reset held low at least 100 ns
// R09: outputs valid after recovery time
// R10: power-up reset held at least 100 ns
// R11: suspend releases busy within 10/20 us
// R12: 500 us from resume to suspend
// R13: main block erase within 5 s
// R14: chip erase within 1400 s
// R15: block program within 2.4 s
// R16: status reads use array read timing
// R17: busy low throughout embedded operation
`timescale 1ns/10ps
`default_nettype none
module fwrt_host #(
  parameter longint unsigned TIMEOUT_CYC = fwrt_pkg::TIMEOUT_CYC,
  parameter int unsigned GAP_CYC = fwrt_pkg::GAP_CYC,
  parameter int unsigned ABORT_CYC = fwrt_pkg::ABORT_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // user side
  input wire logic req_valid_i,
  input wire fwrt_pkg::fwrt_req_s req_i,
  input wire logic use_ce_frame_i,
  input wire logic flash_reset_i,
  output logic req_ready_o,
  output logic busy_o,
  output logic timeout_o,
  output logic ready_o,
  // flash pins
  input wire logic ready_busy_n_i,
  output fwrt_pkg::fwrt_strobe_s strobe_o,
  output logic [22:0] addr_o,
  output logic [15:0] data_o,
  output logic data_oe_o
);
  fwrt_pkg::fwrt_state_e state;
  logic [fwrt_pkg::CNT_W-1:0] cnt;
  logic [fwrt_pkg::TO_W-1:0] to_cnt;
  logic [fwrt_pkg::TO_W-1:0] gap_cnt;
  logic ce_frame;
  logic gap_ok;

  function automatic logic done(input logic [fwrt_pkg::CNT_W-1:0] c, input int unsigned n);
    done = (c >= fwrt_pkg::CNT_W'(n - 1));
  endfunction

  assign gap_ok = (gap_cnt == '0);
  // suspend waits out the resume gap
  assign req_ready_o = (state == fwrt_pkg::FWRT_IDLE) && !flash_reset_i &&
    (gap_ok || !req_i.suspend); // R12
  assign ready_o = (state == fwrt_pkg::FWRT_IDLE); // R09
  assign busy_o = !ready_busy_n_i; // R17

  // sequencer
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= fwrt_pkg::FWRT_RESET;
      cnt <= '0;
      ce_frame <= 1'b0;
    end else begin
      unique case (state)
        fwrt_pkg::FWRT_RESET: begin
          // hold long enough, and wait out an abort when busy
          cnt <= cnt + 1'b1;
          if (done(cnt, fwrt_pkg::RST_CYC) && !flash_reset_i &&
              (ready_busy_n_i || done(cnt, ABORT_CYC))) begin // R08 R10 R06 R07
            state <= fwrt_pkg::FWRT_RECOVER;
            cnt <= '0;
          end
        end
        fwrt_pkg::FWRT_RECOVER: begin
          // recovery counts from the later of reset release and busy release
          cnt <= ready_busy_n_i ? cnt + 1'b1 : '0; // R09
          if (done(cnt, fwrt_pkg::REC_CYC) && ready_busy_n_i) begin // R09
            state <= fwrt_pkg::FWRT_IDLE;
            cnt <= '0;
          end
        end
        fwrt_pkg::FWRT_IDLE: begin
          cnt <= '0;
          if (flash_reset_i) begin
            state <= fwrt_pkg::FWRT_RESET;
          end else if (req_valid_i && req_ready_o) begin
            ce_frame <= use_ce_frame_i; // R01
            state <= fwrt_pkg::FWRT_PULSE;
          end
        end
        fwrt_pkg::FWRT_PULSE: begin
          cnt <= cnt + 1'b1;
          if (done(cnt, fwrt_pkg::WP_CYC)) begin // R02
            state <= fwrt_pkg::FWRT_HIGH;
            cnt <= '0;
          end
        end
        fwrt_pkg::FWRT_HIGH: begin
          cnt <= cnt + 1'b1;
          if (done(cnt, fwrt_pkg::WPH_CYC)) begin // R03
            state <= fwrt_pkg::FWRT_SETTLE;
            cnt <= '0;
          end
        end
        fwrt_pkg::FWRT_SETTLE: begin
          // let the busy pin fall before trusting it
          cnt <= cnt + 1'b1;
          if (done(cnt, fwrt_pkg::SETTLE_CYC)) begin // R04 R05
            state <= fwrt_pkg::FWRT_IDLE;
            cnt <= '0;
          end
        end
        default: begin
          state <= fwrt_pkg::FWRT_RESET;
        end
      endcase
    end
  end

  // pins
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      strobe_o <= '{ce_n: 1'b1, we_n: 1'b1, rst_n: 1'b0};
      addr_o <= '0;
      data_o <= '0;
      data_oe_o <= 1'b0;
    end else begin
      // reset pin falls on the edge that enters the reset state, so it spans the full count
      strobe_o.rst_n <= !(state == fwrt_pkg::FWRT_RESET ||
        (state == fwrt_pkg::FWRT_IDLE && flash_reset_i)) ||
        (state == fwrt_pkg::FWRT_RESET && done(cnt, fwrt_pkg::RST_CYC) && !flash_reset_i &&
        (ready_busy_n_i || done(cnt, ABORT_CYC))); // R08
      if (state == fwrt_pkg::FWRT_IDLE && req_valid_i && req_ready_o) begin
        addr_o <= req_i.addr;
        data_o <= req_i.data;
        data_oe_o <= 1'b1;
        // framing strobe falls on the same edge as the other one
        strobe_o.ce_n <= 1'b0; // R01
        strobe_o.we_n <= 1'b0;
      end else if (state == fwrt_pkg::FWRT_PULSE && done(cnt, fwrt_pkg::WP_CYC)) begin
        // the framing strobe rises first and ends the pulse
        if (ce_frame) begin
          strobe_o.ce_n <= 1'b1; // R01
        end else begin
          strobe_o.we_n <= 1'b1; // R02
        end
      end else if (state == fwrt_pkg::FWRT_HIGH && done(cnt, fwrt_pkg::WPH_CYC)) begin
        strobe_o.ce_n <= 1'b1;
        strobe_o.we_n <= 1'b1;
        data_oe_o <= 1'b0;
      end
    end
  end

  // resume-to-suspend spacing
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_cnt <= '0;
    end else if (state == fwrt_pkg::FWRT_IDLE && req_valid_i && req_ready_o && req_i.resume) begin
      gap_cnt <= fwrt_pkg::TO_W'(GAP_CYC); // R12
    end else if (!gap_ok) begin
      gap_cnt <= gap_cnt - 1'b1;
    end
  end

  // embedded operation watchdog sized for the longest erase
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      to_cnt <= '0;
      timeout_o <= 1'b0;
    end else if (ready_busy_n_i) begin
      to_cnt <= '0;
    end else begin
      if (to_cnt == fwrt_pkg::TO_W'(TIMEOUT_CYC)) begin
        timeout_o <= 1'b1; // R13 R14 R15
      end else begin
        to_cnt <= to_cnt + 1'b1;
      end
    end
  end

  // R16 status reads are ordinary reads, not issued by this block

  pulse_low_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R02
    $fell(strobe_o.we_n) |-> !strobe_o.we_n [*3])
    else $error("write pulse too short");
  ce_pulse_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R02
    $fell(strobe_o.ce_n) |-> !strobe_o.ce_n [*3])
    else $error("chip enable pulse too short");
  pulse_high_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R03
    $rose(strobe_o.ce_n) |-> strobe_o.ce_n [*2])
    else $error("inactive gap too short");
  reset_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R08
    $fell(strobe_o.rst_n) |-> !strobe_o.rst_n [*5])
    else $error("reset pulse too short");
  recover_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R09
    $rose(strobe_o.rst_n) |-> !ready_o [*7])
    else $error("ready before recovery");
  idle_ce_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R01
    (state == fwrt_pkg::FWRT_IDLE) |-> strobe_o.ce_n && strobe_o.we_n)
    else $error("strobe low while idle");
  busy_recover_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R09
    (state == fwrt_pkg::FWRT_RECOVER && $rose(ready_busy_n_i)) |-> !ready_o [*8])
    else $error("ready before busy recovery");
  gap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R12
    (req_valid_i && req_ready_o && req_i.resume) |=> !gap_ok)
    else $error("resume gap not armed");
  settle_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R05
    $rose(strobe_o.ce_n) |-> !ready_o [*8])
    else $error("idle before busy settles");
  write_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(strobe_o.we_n) ##[1:20] ready_o);
  ce_frame_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(strobe_o.ce_n) && use_ce_frame_i);
  abort_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    !strobe_o.rst_n && busy_o);
endmodule
`default_nettype wire

// ---- bench/fwrt_flash_model.sv ----
// Purpose: behavioural flash device on the far side of fwrt_host
// Assumes: open-drain busy pin, pulled up by the bench
// Notes: any command but read array or suspend starts a long operation
`timescale 1ns/10ps
`default_nettype none
module fwrt_flash_model #(
  parameter int BUSY_NS = 4000
) (
  // host pins
  input wire fwrt_pkg::fwrt_strobe_s strobe_i,
  input wire logic [15:0] data_i,
  input wire logic data_oe_i,
  // status pin
  output wire ready_busy_n_o
);
  logic busy = 1'b0;
  wire pulse_n = strobe_i.ce_n | strobe_i.we_n;
  // busy pin and status bit released together
  assign ready_busy_n_o = busy ? 1'b0 : 1'bz;
  // command latched when the earlier strobe rises
  always @(posedge pulse_n) begin
    if (strobe_i.rst_n && data_oe_i && data_i == fwrt_pkg::CMD_ERASE_SUSPEND)
      #40 busy = 1'b0;
    else if (strobe_i.rst_n && data_oe_i && data_i != 16'h00ff)
      #60 busy = 1'b1;
  end
  always @(posedge busy) #BUSY_NS busy = 1'b0;
  always @(negedge strobe_i.rst_n) #80 busy = 1'b0;
endmodule
`default_nettype wire

// ---- bench/flash_write_reset_timing_test.sv ----
// Purpose: self-checking bench for fwrt_host
// Assumes: flash model on the far side
// Notes: short counts set by parameter
`timescale 1ns/10ps
`default_nettype none
module flash_write_reset_timing_test;
  localparam int GAP = 150;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_valid_i = 1'b0;
  fwrt_pkg::fwrt_req_s req_i = '0;
  logic use_ce_frame_i = 1'b0;
  logic flash_reset_i = 1'b0;
  logic req_ready_o, busy_o, timeout_o, ready_o, data_oe_o;
  fwrt_pkg::fwrt_strobe_s strobe_o;
  logic [22:0] addr_o;
  logic [15:0] data_o;
  tri1 ready_busy_n;
  int n_mismatch = 0;
  int checked = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  fwrt_host #(.TIMEOUT_CYC(150), .GAP_CYC(GAP), .ABORT_CYC(10)) i_dut (.sys_clk_i, .reset_i,
    .req_valid_i, .req_i, .use_ce_frame_i, .flash_reset_i, .req_ready_o, .busy_o, .timeout_o,
    .ready_o, .ready_busy_n_i(ready_busy_n), .strobe_o, .addr_o, .data_o, .data_oe_o);
  fwrt_flash_model i_flash (.strobe_i(strobe_o), .data_i(data_o), .data_oe_i(data_oe_o),
    .ready_busy_n_o(ready_busy_n));
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("n_mismatch=%0d checked=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (!(ready_o === 1'b1 && req_ready_o === 1'b1) && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    check(1, 32'(n < 300));
  endtask
  // one write; counts the strobe overlap and notes which strobe ends it
  task automatic put(input logic [15:0] d, input logic ce, input logic sus, output time tk);
    int n;
    logic f;
    logic ce_seen;
    wait_idle();
    @(posedge sys_clk_i);
    use_ce_frame_i <= ce;
    req_i <= '{23'h1a5a5a, d, sus, d == fwrt_pkg::CMD_ERASE_RESUME};
    req_valid_i <= 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 200);
    @(posedge sys_clk_i);
    tk = $time;
    req_valid_i <= 1'b0;
    n = 0;
    f = 1'b0;
    ce_seen = 1'bx;
    repeat (6) begin
      @(negedge sys_clk_i);
      if (strobe_o.ce_n === 1'b0 && strobe_o.we_n === 1'b0) n++;
      else if (n > 0 && !f) begin
        f = 1'b1;
        ce_seen = strobe_o.ce_n;
      end
    end
    check(fwrt_pkg::WP_CYC, n);
    check({ce, d}, {ce_seen, data_o});
  endtask
  task automatic s_busy();
    time t;
    int n;
    put(16'h0040, 1'b0, 1'b0, t);
    repeat (3) @(negedge sys_clk_i);
    check(2'b10, {busy_o, ready_o});
    check(0, timeout_o);
    wait_idle();
    n = 0;
    while (busy_o !== 1'b0 && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    check(2'b01, {busy_o, ready_busy_n});
    check(1, timeout_o);
    put(16'h00ff, 1'b1, 1'b0, t);
    repeat (3) @(negedge sys_clk_i);
    check(0, busy_o);
  endtask
  task automatic s_gap();
    time tr;
    time ts;
    put(fwrt_pkg::CMD_ERASE_RESUME, 1'b0, 1'b0, tr);
    put(fwrt_pkg::CMD_ERASE_SUSPEND, 1'b1, 1'b1, ts);
    check(1, 32'((ts - tr) >= GAP * 20));
    repeat (3) @(negedge sys_clk_i);
    check(0, busy_o);
  endtask
  task automatic s_abort();
    time t;
    int n;
    put(16'h0020, 1'b0, 1'b0, t);
    @(posedge sys_clk_i);
    flash_reset_i <= 1'b1;
    n = 0;
    while (strobe_o.rst_n !== 1'b0 && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    @(posedge sys_clk_i);
    flash_reset_i <= 1'b0;
    n = 1;
    while (strobe_o.rst_n === 1'b0 && n < 50) begin
      @(negedge sys_clk_i);
      n++;
    end
    check(1, 32'(n >= fwrt_pkg::RST_CYC));
    check(0, busy_o);
    n = 0;
    while (ready_o !== 1'b1 && n < 50) begin
      @(negedge sys_clk_i);
      n++;
    end
    check(1, 32'(n >= fwrt_pkg::REC_CYC));
    wait_idle();
    check(0, ready_o === 1'b1 && busy_o === 1'b1);
  endtask
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    check(2'b10, {strobe_o.ce_n, strobe_o.rst_n});
    reset_i <= 1'b0;
    s_busy();
    s_gap();
    s_abort();
    check(1, timeout_o);
    complete_run();
  end
endmodule
`default_nettype wire
